// file: rtl/slpe_regs.svh
// register map constants for the link parameter and error monitor bank
// assumes an 12-bit register address and 8-bit data from the serial control port
`ifndef SLPE_REGS_SVH
`define SLPE_REGS_SVH
`define SLPE_ADDR_M 12'h456
`define SLPE_ADDR_CSN 12'h457
`define SLPE_ADDR_NP 12'h458
`define SLPE_ADDR_S 12'h459
`define SLPE_ADDR_HDCF 12'h45a
`define SLPE_ADDR_RES1 12'h45b
`define SLPE_ADDR_RES2 12'h45c
`define SLPE_ADDR_CHK 12'h45d
`define SLPE_ADDR_ERRMON 12'h46b
`define SLPE_ADDR_DESKEW 12'h46c
`define SLPE_ADDR_BAD_DISPARITY_FLAG 12'h46d
`define SLPE_ADDR_THRESH 12'h47c
`define SLPE_RST_M 8'h01
`define SLPE_RST_CSN 8'h0f
`define SLPE_RST_NP 8'h2f
`define SLPE_RST_S 8'h20
`define SLPE_RST_HDCF 8'h80
`define SLPE_RST_CHK 8'h45
`define SLPE_RST_DESKEW 8'h0f
`define SLPE_RST_THRESH 8'hff
`define SLPE_MASK_CSN 8'hdf
`define SLPE_MASK_HDCF 8'h9f
`define SLPE_MASK_ERRMON 8'h73
`define SLPE_CNT_MAX 8'hff
`define SLPE_SEL_BAD_DISPARITY_FLAG 2'h0
`define SLPE_SEL_NIT 2'h1
`define SLPE_SEL_UCC 2'h2
`define SLPE_BIT_IRQCLR 7
`define SLPE_LANES 8
`define SLPE_FLD_MONITOR_LANE_SELECT 6:4
`define SLPE_FLD_CNTSEL 1:0
`define SLPE_FLD_LANEADDR 2:0
`define SLPE_MASK_LOW7 8'h7f
`endif

// file: rtl/slpe_pkg.sv
// types shared by the link parameter bank and its helpers
// assumes slpe_regs.svh constants
package slpe_pkg;
  typedef logic [7:0] slpe_byte_t;
  typedef logic [2:0] slpe_lane_t;
endpackage : slpe_pkg

// file: rtl/slpe_err_counter.sv
// one saturating 8-bit error counter for a single lane and error type
// assumes error pulses are synchronous to core_clk
`timescale 1ns/1ps
`include "slpe_regs.svh"
module slpe_err_counter
  import slpe_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic err_pulse,
  output slpe_byte_t count
);
  typedef struct packed {slpe_byte_t cnt;} slpe_cnt_state_t;
  slpe_cnt_state_t state;
  slpe_cnt_state_t next_state;
  // hold at the top so software never sees a wrapped small count
  always_comb
  begin
    next_state = state;
    if (err_pulse && state.cnt != `SLPE_CNT_MAX)
    begin
      next_state.cnt = state.cnt + 8'h01;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end
  assign count = state.cnt;
  chk_count_saturate: assert property (@(posedge core_clk) disable iff (!reset_n)
    state.cnt == `SLPE_CNT_MAX |=> state.cnt == `SLPE_CNT_MAX)
    else $error("error counter wrapped");
endmodule : slpe_err_counter

// file: rtl/slpe_checksum.sv
// link parameter checksum calculator for lane 0
// assumes field bytes come from registers on the same clock
`timescale 1ns/1ps
`include "slpe_regs.svh"
module slpe_checksum
  import slpe_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic method_sel,
  input slpe_byte_t fields [0:7],
  output slpe_byte_t checksum
);
  typedef struct packed {slpe_byte_t sum;} slpe_chk_state_t;
  slpe_chk_state_t state;
  slpe_chk_state_t next_state;
  slpe_byte_t total;
  // method 1 sums whole octets, method 0 sums the octets with bit 7 masked
  always_comb
  begin
    next_state = state;
    total = '0;
    for (int i = 0; i < 8; i++)
    begin
      total = total + (method_sel ? fields[i] : (fields[i] & `SLPE_MASK_LOW7));
    end
    next_state.sum = total;
  end
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '{sum: `SLPE_RST_CHK};
    end
    else
    begin
      state <= next_state;
    end
  end
  assign checksum = state.sum;
endmodule : slpe_checksum

// file: rtl/slpe_param_errmon.sv
// register bank for link parameters, error counter readback, deskew and disparity flags
// assumes the serial control port delivers one-cycle write and read strobes
// How it works
// - converters field stores count minus one
// - samples field one or two; version resets 001
// - checksum register computed, method from control bit
// - write selects, read returns chosen counter
// - three-bit lane select picks counter lane
// - two-bit select picks counter type
// - deskew bits enable lanes, reset four lanes
// - disparity flag sets at count threshold
// - irq clear bit clears addressed lane flag
`timescale 1ns/1ps
`include "slpe_regs.svh"
module slpe_param_errmon
  import slpe_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output slpe_byte_t reg_rdata,
  input wire logic checksum_method,
  input wire logic [7:0] err_bad_disparity,
  input wire logic [7:0] err_not_in_table,
  input wire logic [7:0] err_unexpected_ctrl,
  output logic [7:0] lane_deskew,
  output logic [7:0] bad_disparity_irq,
  output logic [7:0] converters_minus_one
);
  // ==========================================
  // state
  typedef struct packed {
    slpe_byte_t m;
    slpe_byte_t csn;
    slpe_byte_t np;
    slpe_byte_t s;
    slpe_byte_t hdcf;
    slpe_byte_t res1;
    slpe_byte_t res2;
    slpe_byte_t chk;
    slpe_lane_t monitor_lane_select;
    logic [1:0] monitor_counter_select;
    slpe_byte_t deskew;
    slpe_byte_t thresh;
    slpe_byte_t bad_disparity_flag;
    slpe_byte_t rdata;
    logic chk_written;
  } slpe_state_t;
  slpe_state_t state;
  slpe_state_t next_state;
  slpe_byte_t bad_cnt [0:7];
  slpe_byte_t nit_cnt [0:7];
  slpe_byte_t ucc_cnt [0:7];
  slpe_byte_t chk_fields [0:7];
  slpe_byte_t lane0_checksum;
  slpe_byte_t error_count_readback;
  logic [7:0] pin_sync1 [0:2];
  logic [7:0] pin_sync2 [0:2];

  // ==========================================
  // error pulses come from the lane logic on another timing path, so sync them
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int k = 0; k < 3; k++)
      begin
        pin_sync1[k] <= '0;
        pin_sync2[k] <= '0;
      end
    end
    else
    begin
      pin_sync1[0] <= err_bad_disparity;
      pin_sync1[1] <= err_not_in_table;
      pin_sync1[2] <= err_unexpected_ctrl;
      for (int k = 0; k < 3; k++)
      begin
        pin_sync2[k] <= pin_sync1[k];
      end
    end
  end

  // ==========================================
  // per-lane counters for each error type
  generate
    for (genvar g = 0; g < `SLPE_LANES; g++)
    begin : g_lane
      slpe_err_counter u_bad (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .err_pulse(pin_sync2[0][g]),
        .count(bad_cnt[g])
      );
      slpe_err_counter u_nit (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .err_pulse(pin_sync2[1][g]),
        .count(nit_cnt[g])
      );
      slpe_err_counter u_ucc (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .err_pulse(pin_sync2[2][g]),
        .count(ucc_cnt[g])
      );
    end
  endgenerate

  // ==========================================
  // checksum over the stored link parameter octets and the deskew register
  assign chk_fields[0] = state.m;
  assign chk_fields[1] = state.csn;
  assign chk_fields[2] = state.np;
  assign chk_fields[3] = state.s;
  assign chk_fields[4] = state.hdcf;
  assign chk_fields[5] = state.res1;
  assign chk_fields[6] = state.res2;
  assign chk_fields[7] = state.deskew;
  slpe_checksum u_chk (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .method_sel(checksum_method),
    .fields(chk_fields),
    .checksum(lane0_checksum)
  );

  // ==========================================
  // readback mux for the monitor address
  always_comb
  begin
    unique case (state.monitor_counter_select)
      `SLPE_SEL_BAD_DISPARITY_FLAG: error_count_readback = bad_cnt[state.monitor_lane_select];
      `SLPE_SEL_NIT: error_count_readback = nit_cnt[state.monitor_lane_select];
      `SLPE_SEL_UCC: error_count_readback = ucc_cnt[state.monitor_lane_select];
      default: error_count_readback = '0;
    endcase
  end

  // ==========================================
  // register writes, reads and flag updates
  always_comb
  begin
    next_state = state;
    // computed value tracks until software overwrites the checksum
    if (!state.chk_written)
    begin
      next_state.chk = lane0_checksum;
    end
    // flags set on reaching threshold; set beats a same-cycle clear
    for (int i = 0; i < `SLPE_LANES; i++)
    begin
      if (reg_write && reg_addr == `SLPE_ADDR_BAD_DISPARITY_FLAG && reg_wdata[`SLPE_BIT_IRQCLR]
          && reg_wdata[`SLPE_FLD_LANEADDR] == 3'(i))
      begin
        next_state.bad_disparity_flag[i] = 1'b0;
      end
      if (bad_cnt[i] >= state.thresh)
      begin
        next_state.bad_disparity_flag[i] = 1'b1;
      end
    end
    if (reg_write)
    begin
      unique case (reg_addr)
        `SLPE_ADDR_M: next_state.m = reg_wdata;
        `SLPE_ADDR_CSN: next_state.csn = reg_wdata & `SLPE_MASK_CSN;
        `SLPE_ADDR_NP: next_state.np = reg_wdata;
        `SLPE_ADDR_S: next_state.s = reg_wdata;
        `SLPE_ADDR_HDCF: next_state.hdcf = reg_wdata & `SLPE_MASK_HDCF;
        `SLPE_ADDR_RES1: next_state.res1 = reg_wdata;
        `SLPE_ADDR_RES2: next_state.res2 = reg_wdata;
        `SLPE_ADDR_CHK:
        begin
          next_state.chk = reg_wdata;
          next_state.chk_written = 1'b1;
        end
        `SLPE_ADDR_ERRMON:
        begin
          next_state.monitor_lane_select = reg_wdata[`SLPE_FLD_MONITOR_LANE_SELECT];
          next_state.monitor_counter_select = reg_wdata[`SLPE_FLD_CNTSEL];
        end
        `SLPE_ADDR_DESKEW: next_state.deskew = reg_wdata;
        `SLPE_ADDR_THRESH: next_state.thresh = reg_wdata;
        default: ;
      endcase
    end
    // read data registered; unmapped addresses read zero
    if (reg_read)
    begin
      unique case (reg_addr)
        `SLPE_ADDR_M: next_state.rdata = state.m;
        `SLPE_ADDR_CSN: next_state.rdata = state.csn;
        `SLPE_ADDR_NP: next_state.rdata = state.np;
        `SLPE_ADDR_S: next_state.rdata = state.s;
        `SLPE_ADDR_HDCF: next_state.rdata = state.hdcf;
        `SLPE_ADDR_RES1: next_state.rdata = state.res1;
        `SLPE_ADDR_RES2: next_state.rdata = state.res2;
        `SLPE_ADDR_CHK: next_state.rdata = state.chk;
        `SLPE_ADDR_ERRMON: next_state.rdata = error_count_readback;
        `SLPE_ADDR_DESKEW: next_state.rdata = state.deskew;
        `SLPE_ADDR_BAD_DISPARITY_FLAG: next_state.rdata = state.bad_disparity_flag;
        `SLPE_ADDR_THRESH: next_state.rdata = state.thresh;
        default: next_state.rdata = '0;
      endcase
    end
  end

  // ==========================================
  // state register; reset values follow the register map
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0;
      state.m <= `SLPE_RST_M;
      state.csn <= `SLPE_RST_CSN;
      state.np <= `SLPE_RST_NP;
      state.s <= `SLPE_RST_S;
      state.hdcf <= `SLPE_RST_HDCF;
      state.chk <= `SLPE_RST_CHK;
      state.deskew <= `SLPE_RST_DESKEW;
      state.thresh <= `SLPE_RST_THRESH;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================
  // outputs come straight from the state flops
  assign reg_rdata = state.rdata;
  assign lane_deskew = state.deskew;
  assign bad_disparity_irq = state.bad_disparity_flag;
  assign converters_minus_one = state.m;

  // ==========================================
  // checks
  // a flag must follow its count within one cycle, else software misses a bad lane
  chk_flag_sets: assert property (@(posedge core_clk) disable iff (!reset_n)
    (bad_cnt[0] >= state.thresh) |=> state.bad_disparity_flag[0])
    else $error("disparity flag missed threshold");
  chk_flag_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
    state.bad_disparity_flag[0] && !(reg_write && reg_addr == `SLPE_ADDR_BAD_DISPARITY_FLAG)
    |=> state.bad_disparity_flag[0])
    else $error("disparity flag dropped");
  chk_set_wins: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_write && reg_addr == `SLPE_ADDR_BAD_DISPARITY_FLAG && reg_wdata[`SLPE_BIT_IRQCLR]
    && reg_wdata[`SLPE_FLD_LANEADDR] == 3'h0 && bad_cnt[0] >= state.thresh
    |=> state.bad_disparity_flag[0])
    else $error("clear beat a standing threshold");
  chk_readback_sel: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_read && reg_addr == `SLPE_ADDR_ERRMON && state.monitor_counter_select == 2'h3
    |=> reg_rdata == 8'h00)
    else $error("unused select not zero");
  chk_readback_bad: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_read && reg_addr == `SLPE_ADDR_ERRMON && state.monitor_counter_select == 2'h0
    |=> reg_rdata == $past(bad_cnt[state.monitor_lane_select]))
    else $error("wrong counter read back");
  chk_sel_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_write && reg_addr == `SLPE_ADDR_ERRMON
    |=> state.monitor_lane_select == $past(reg_wdata[`SLPE_FLD_MONITOR_LANE_SELECT]))
    else $error("lane select not stored");
  chk_deskew_out: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_write && reg_addr == `SLPE_ADDR_DESKEW |=> lane_deskew == $past(reg_wdata))
    else $error("deskew not applied");
  chk_irq_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_write && reg_addr == `SLPE_ADDR_BAD_DISPARITY_FLAG && reg_wdata[`SLPE_BIT_IRQCLR]
    && reg_wdata[`SLPE_FLD_LANEADDR] == 3'h0 && bad_cnt[0] < state.thresh
    |=> !state.bad_disparity_flag[0])
    else $error("irq clear ignored");
  chk_conv_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_write && reg_addr == `SLPE_ADDR_M |=> converters_minus_one == $past(reg_wdata))
    else $error("converter field not stored");
  chk_version_keep: assert property (@(posedge core_clk) disable iff (!reset_n)
    !(reg_write && reg_addr == `SLPE_ADDR_S) |=> state.s == $past(state.s))
    else $error("version field changed");
  chk_chk_track: assert property (@(posedge core_clk) disable iff (!reset_n)
    !state.chk_written && !(reg_write && reg_addr == `SLPE_ADDR_CHK)
    |=> state.chk == $past(lane0_checksum))
    else $error("checksum not tracking");
  chk_rdata_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    !reg_read |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  cov_flag: cover property (@(posedge core_clk) disable iff (!reset_n)
    $rose(state.bad_disparity_flag[0]));
  cov_saturate: cover property (@(posedge core_clk) disable iff (!reset_n)
    nit_cnt[7] == `SLPE_CNT_MAX);
  cov_sel_read: cover property (@(posedge core_clk) disable iff (!reset_n)
    reg_write && reg_addr == `SLPE_ADDR_ERRMON ##1 reg_read && reg_addr == `SLPE_ADDR_ERRMON);
  cov_clear: cover property (@(posedge core_clk) disable iff (!reset_n)
    $fell(state.bad_disparity_flag[0]));
endmodule : slpe_param_errmon

// file: bench/slpe_tx_model.sv
// far-side transmitter model: raises per-lane error pulses in bursts
// assumes the bench starts one burst at a time and waits while busy
`timescale 1ns/1ps
module slpe_tx_model
  import slpe_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic slow,
  input wire slpe_lane_t lane,
  input wire logic [1:0] kind,
  input wire logic [8:0] len,
  output logic busy,
  output logic [7:0] err_bad_disparity,
  output logic [7:0] err_not_in_table,
  output logic [7:0] err_unexpected_ctrl
);
  logic [8:0] left;
  logic gap;
  logic slow_q;
  slpe_lane_t cur_lane;
  logic [1:0] cur_kind;
  assign busy = go || (left != 9'h000);
  // a slow burst leaves an idle cycle between errors, like a sparse bad link
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      left <= 9'h000;
      gap <= 1'b0;
      slow_q <= 1'b0;
      cur_lane <= 3'h0;
      cur_kind <= 2'h0;
      err_bad_disparity <= 8'h00;
      err_not_in_table <= 8'h00;
      err_unexpected_ctrl <= 8'h00;
    end
    else
    begin
      err_bad_disparity <= 8'h00;
      err_not_in_table <= 8'h00;
      err_unexpected_ctrl <= 8'h00;
      if (go)
      begin
        left <= len;
        cur_lane <= lane;
        cur_kind <= kind;
        slow_q <= slow;
        gap <= 1'b0;
      end
      else if (left != 9'h000 && !gap)
      begin
        left <= left - 9'h001;
        gap <= slow_q;
        err_bad_disparity[cur_lane] <= (cur_kind == 2'h0);
        err_not_in_table[cur_lane] <= (cur_kind == 2'h1);
        err_unexpected_ctrl[cur_lane] <= (cur_kind == 2'h2);
      end
      else
        gap <= 1'b0;
    end
  end
endmodule : slpe_tx_model

// file: bench/serial_link_param_errmon_tb.sv
// self-checking bench for the link parameter and error monitor bank
// assumes the register port takes one-cycle strobes, read data a cycle later
`timescale 1ns/1ps
`include "slpe_regs.svh"
module serial_link_param_errmon_tb;
  import slpe_pkg::*;
  logic core_clk;
  logic reset_n;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic checksum_method;
  logic go;
  logic slow;
  logic busy;
  slpe_lane_t lane;
  logic [1:0] kind;
  logic [8:0] len;
  slpe_byte_t reg_rdata;
  logic [7:0] e_bd;
  logic [7:0] e_nit;
  logic [7:0] e_ucc;
  logic [7:0] lane_deskew;
  logic [7:0] bad_disparity_irq;
  logic [7:0] converters_minus_one;
  int bad_count;
  int checks;
  slpe_param_errmon i_slpe_param_errmon (.core_clk(core_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .checksum_method(checksum_method),
    .err_bad_disparity(e_bd), .err_not_in_table(e_nit), .err_unexpected_ctrl(e_ucc),
    .lane_deskew(lane_deskew), .bad_disparity_irq(bad_disparity_irq),
    .converters_minus_one(converters_minus_one));
  slpe_tx_model i_slpe_tx_model (.core_clk(core_clk), .reset_n(reset_n), .go(go),
    .slow(slow), .lane(lane), .kind(kind), .len(len), .busy(busy),
    .err_bad_disparity(e_bd), .err_not_in_table(e_nit), .err_unexpected_ctrl(e_ucc));
  // ==========================================
  // clock, tasks
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk_byte(input string what, input slpe_byte_t exp, input slpe_byte_t got);
    checks++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk_byte
  // strobes drop at the same edge that takes them, so tasks never collide
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    @(negedge core_clk);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input slpe_byte_t exp, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(negedge core_clk);
    chk_byte(what, exp, reg_rdata);
  endtask : rd_chk
  // sync stages plus counter update need a few cycles after the last pulse
  task automatic burst(input slpe_lane_t l, input logic [1:0] k, input int n, input logic s);
    int i;
    @(posedge core_clk);
    lane <= l;
    kind <= k;
    len <= n[8:0];
    slow <= s;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    for (i = 0; i < 1000 && busy; i++)
      @(posedge core_clk);
    repeat (6) @(posedge core_clk);
  endtask : burst
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // ==========================================
  // scenarios
  task automatic test_reset();
    rd_chk(`SLPE_ADDR_M, 8'h01, "converters");
    rd_chk(`SLPE_ADDR_CSN, 8'h0f, "resolution");
    rd_chk(`SLPE_ADDR_NP, 8'h2f, "subclass");
    rd_chk(`SLPE_ADDR_S, 8'h20, "version");
    rd_chk(`SLPE_ADDR_HDCF, 8'h80, "density");
    rd_chk(`SLPE_ADDR_DESKEW, 8'h0f, "deskew reg");
    rd_chk(`SLPE_ADDR_BAD_DISPARITY_FLAG, 8'h00, "flags reg");
    rd_chk(`SLPE_ADDR_CHK, 8'h6e, "sum masked");
    chk_byte("deskew out", 8'h0f, lane_deskew);
    chk_byte("conv out", 8'h01, converters_minus_one);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_fields();
    wr(`SLPE_ADDR_M, 8'h00);
    chk_byte("conv out", 8'h00, converters_minus_one);
    wr(`SLPE_ADDR_CSN, 8'hff);
    rd_chk(`SLPE_ADDR_CSN, 8'hdf, "csn mask");
    wr(`SLPE_ADDR_HDCF, 8'hff);
    rd_chk(`SLPE_ADDR_HDCF, 8'h9f, "hdcf mask");
    wr(`SLPE_ADDR_S, 8'h01);
    rd_chk(`SLPE_ADDR_S, 8'h01, "two samples");
    @(posedge core_clk);
    checksum_method <= 1'b1;
    wr(12'h460, 8'haa);
    rd_chk(12'h460, 8'h00, "unmapped");
    rd_chk(`SLPE_ADDR_CHK, 8'hbd, "sum whole");
    wr(`SLPE_ADDR_CHK, 8'h3c);
    rd_chk(`SLPE_ADDR_CHK, 8'h3c, "checksum");
    wr(`SLPE_ADDR_DESKEW, 8'ha5);
    chk_byte("deskew out", 8'ha5, lane_deskew);
    $display("test_fields done");
  endtask : test_fields
  task automatic test_counters();
    burst(3'h1, 2'h0, 4, 1'b0);
    burst(3'h3, 2'h1, 2, 1'b1);
    burst(3'h6, 2'h2, 5, 1'b0);
    wr(`SLPE_ADDR_ERRMON, 8'h10);
    rd_chk(`SLPE_ADDR_ERRMON, 8'h04, "bd lane1");
    wr(`SLPE_ADDR_ERRMON, 8'h31);
    rd_chk(`SLPE_ADDR_ERRMON, 8'h02, "nit lane3");
    wr(`SLPE_ADDR_ERRMON, 8'h62);
    rd_chk(`SLPE_ADDR_ERRMON, 8'h05, "ucc lane6");
    wr(`SLPE_ADDR_ERRMON, 8'h00);
    rd_chk(`SLPE_ADDR_ERRMON, 8'h00, "bd lane0");
    wr(`SLPE_ADDR_ERRMON, 8'h13);
    rd_chk(`SLPE_ADDR_ERRMON, 8'h00, "code 11");
    burst(3'h7, 2'h1, 300, 1'b0);
    wr(`SLPE_ADDR_ERRMON, 8'h71);
    rd_chk(`SLPE_ADDR_ERRMON, 8'hff, "saturate");
    $display("test_counters done");
  endtask : test_counters
  task automatic test_disparity();
    // lane 1 already holds four bad disparity errors, so it flags at threshold 3 too
    wr(`SLPE_ADDR_THRESH, 8'h03);
    burst(3'h5, 2'h0, 2, 1'b0);
    rd_chk(`SLPE_ADDR_BAD_DISPARITY_FLAG, 8'h02, "below thresh");
    burst(3'h5, 2'h0, 1, 1'b0);
    rd_chk(`SLPE_ADDR_BAD_DISPARITY_FLAG, 8'h22, "at thresh");
    chk_byte("irq out", 8'h22, bad_disparity_irq);
    wr(`SLPE_ADDR_THRESH, 8'hff);
    wr(`SLPE_ADDR_BAD_DISPARITY_FLAG, 8'h85);
    rd_chk(`SLPE_ADDR_BAD_DISPARITY_FLAG, 8'h02, "irq clear");
    $display("test_disparity done");
  endtask : test_disparity
  // ==========================================
  // main sequence and watchdog
  initial
  begin
    bad_count = 0;
    checks = 0;
    reset_n = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    checksum_method = 1'b0;
    go = 1'b0;
    slow = 1'b0;
    lane = 3'h0;
    kind = 2'h0;
    len = 9'h000;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    test_reset();
    test_fields();
    test_counters();
    test_disparity();
    stop_test();
  end
  // the full run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    stop_test();
  end
endmodule : serial_link_param_errmon_tb
